//--- hw/spl_defs.vh
`ifndef SPL_DEFS_VH
`define SPL_DEFS_VH

// Register offsets on the plain register port
`define SPL_CFG_OFFSET 8'hc8
`define SPL_STAT_OFFSET 8'hcc

// Configuration word field positions
`define SPL_PER_LANE_LINE_LOOPBACK_LSB 16
`define SPL_PER_LANE_LINE_LOOPBACK_MSB 19
`define SPL_RSVD20_BIT 20
`define SPL_SPLIT_BIT 21
`define SPL_DLB_ODD_BIT 22
`define SPL_DLB_EVEN_BIT 23
`define SPL_TX_REV_BIT 24
`define SPL_RX_REV_BIT 25
`define SPL_SRST_ODD_BIT 26
`define SPL_SRST_EVEN_BIT 27
`define SPL_PWDN_ODD_BIT 28
`define SPL_PWDN_EVEN_BIT 29
`define SPL_RATE_LSB 30
`define SPL_RATE_MSB 31

// Reset values of the configuration fields
`define SPL_PER_LANE_LINE_LOOPBACK_RST 4'h0
`define SPL_BIT_RST 1'h0
`define SPL_RATE_RST 2'h0

// Lane rate codes
`define SPL_RATE_1G25 2'h0
`define SPL_RATE_2G5 2'h1
`define SPL_RATE_3G125 2'h2
`define SPL_RATE_RSVD 2'h3

// Status word field positions
`define SPL_STAT_SPLIT_PIN 0
`define SPL_STAT_TXREV_PIN 1
`define SPL_STAT_RXREV_PIN 2
`define SPL_STAT_PD_ODD_PIN 3
`define SPL_STAT_PD_EVEN_PIN 4
`define SPL_STAT_RATE_PIN_LSB 5
`define SPL_STAT_RATE_PIN_MSB 6
`define SPL_STAT_EVEN_RST 8
`define SPL_STAT_ODD_RST 9
`define SPL_STAT_EVEN_PD 10
`define SPL_STAT_ODD_PD 11
`define SPL_STAT_RATE_OK 12
`define SPL_STAT_STRAP_DONE 13

`endif

//--- hw/spl_lane_cfg.v
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`include "spl_defs.vh"
module spl_lane_cfg #(
  parameter AW = 8,
  parameter DW = 9,
  parameter LW = 10
) (
  input wire i_clk,
  input wire i_resetn,
  input wire [AW-1:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output wire [31:0] o_rdata,
  input wire i_port_split_strap_pin,
  input wire i_transmit_reverse_strap_pin,
  input wire i_receive_reverse_strap_pin,
  input wire i_odd_port_power_down_strap_pin,
  input wire i_even_port_power_down_strap_pin,
  input wire [1:0] i_lane_rate_strap_pins,
  output wire [3:0] o_per_lane_line_loopback,
  output wire o_port_split_select,
  output wire o_even_port_wide_allowed,
  output wire o_odd_port_active,
  output wire o_even_port_reset,
  output wire o_odd_port_reset,
  output wire o_even_port_power_down,
  output wire o_odd_port_power_down,
  output wire [1:0] o_lane_rate,
  output wire o_lane_rate_valid,
  input wire [DW-1:0] i_even_tx_data,
  input wire [DW-1:0] i_even_dec_data,
  output wire [DW-1:0] o_even_enc_data,
  output wire [DW-1:0] o_even_rx_data,
  input wire [DW-1:0] i_odd_tx_data,
  input wire [DW-1:0] i_odd_dec_data,
  output wire [DW-1:0] o_odd_enc_data,
  output wire [DW-1:0] o_odd_rx_data,
  input wire [4*LW-1:0] i_tx_lanes,
  output wire [4*LW-1:0] o_tx_lanes,
  input wire [4*LW-1:0] i_rx_lanes,
  output wire [4*LW-1:0] o_rx_lanes
);

  localparam [AW-1:0] CFG_ADDR = `SPL_CFG_OFFSET;
  localparam [AW-1:0] STAT_ADDR = `SPL_STAT_OFFSET;

  // Strap synchroniser stages and captured strap levels
  reg [6:0] strap_meta_r;
  reg [6:0] strap_sync_r;
  reg strap_pending_r;

  // Configuration fields
  reg [3:0] per_lane_line_loopback_r;
  reg rsvd20_r;
  reg split_r;
  reg dlb_odd_r;
  reg dlb_even_r;
  reg tx_rev_r;
  reg rx_rev_r;
  reg srst_odd_r;
  reg srst_even_r;
  reg pwdn_odd_r;
  reg pwdn_even_r;
  reg [1:0] rate_r;

  // Derived port controls
  reg even_rst_r;
  reg odd_rst_r;
  reg even_pd_r;
  reg odd_pd_r;
  reg wide_ok_r;
  reg odd_active_r;
  reg rate_ok_r;

  // Read path
  reg [31:0] rdata_r;
  reg [31:0] rdata_nxt;
  reg [31:0] cfg_word;
  reg [31:0] stat_word;

  wire cfg_wr;

  assign cfg_wr = i_wr && (i_addr == CFG_ADDR);

  // Rate code sanity check, used by both the port output and status
  function spl_rate_ok;
    input [1:0] code;
    begin
      case (code)
        `SPL_RATE_1G25: spl_rate_ok = 1'b1;
        `SPL_RATE_2G5: spl_rate_ok = 1'b1;
        `SPL_RATE_3G125: spl_rate_ok = 1'b1;
        default: spl_rate_ok = 1'b0;
      endcase
    end
  endfunction

  // Straps are pins from outside; two flops before any use. Not reset so
  // the pipe is already full of the pin level when reset releases.
  always @(posedge i_clk) begin
    strap_meta_r <= {i_lane_rate_strap_pins, i_even_port_power_down_strap_pin,
                     i_odd_port_power_down_strap_pin, i_receive_reverse_strap_pin,
                     i_transmit_reverse_strap_pin, i_port_split_strap_pin};
    strap_sync_r <= strap_meta_r;
  end

  // Strap capture happens once, at the first edge after reset release
  always @(posedge i_clk) begin
    if (!i_resetn) begin
      strap_pending_r <= 1'b1;
    end else begin
      strap_pending_r <= 1'b0;
    end
  end

  // Software-only fields: line loopback, reserved bit, digital loopback, soft resets
  always @(posedge i_clk) begin
    if (!i_resetn) begin
      per_lane_line_loopback_r <= `SPL_PER_LANE_LINE_LOOPBACK_RST;
      rsvd20_r <= `SPL_BIT_RST;
      dlb_odd_r <= `SPL_BIT_RST;
      dlb_even_r <= `SPL_BIT_RST;
      srst_odd_r <= `SPL_BIT_RST;
      srst_even_r <= `SPL_BIT_RST;
    end else if (cfg_wr) begin
      per_lane_line_loopback_r <= i_wdata[`SPL_PER_LANE_LINE_LOOPBACK_MSB:`SPL_PER_LANE_LINE_LOOPBACK_LSB];
      rsvd20_r <= i_wdata[`SPL_RSVD20_BIT];
      dlb_odd_r <= i_wdata[`SPL_DLB_ODD_BIT];
      dlb_even_r <= i_wdata[`SPL_DLB_EVEN_BIT];
      srst_odd_r <= i_wdata[`SPL_SRST_ODD_BIT];
      srst_even_r <= i_wdata[`SPL_SRST_EVEN_BIT];
    end
  end

  // Strap-seeded fields. A write in the capture cycle wins, as software
  // is meant to override the pins; otherwise the strap is taken once.
  always @(posedge i_clk) begin
    if (!i_resetn) begin
      split_r <= `SPL_BIT_RST;
      tx_rev_r <= `SPL_BIT_RST;
      rx_rev_r <= `SPL_BIT_RST;
      pwdn_odd_r <= `SPL_BIT_RST;
      pwdn_even_r <= `SPL_BIT_RST;
      rate_r <= `SPL_RATE_RST;
    end else if (cfg_wr) begin
      split_r <= i_wdata[`SPL_SPLIT_BIT];
      tx_rev_r <= i_wdata[`SPL_TX_REV_BIT];
      rx_rev_r <= i_wdata[`SPL_RX_REV_BIT];
      pwdn_odd_r <= i_wdata[`SPL_PWDN_ODD_BIT];
      pwdn_even_r <= i_wdata[`SPL_PWDN_EVEN_BIT];
      rate_r <= i_wdata[`SPL_RATE_MSB:`SPL_RATE_LSB];
    end else if (strap_pending_r) begin
      split_r <= strap_sync_r[0];
      tx_rev_r <= strap_sync_r[1];
      rx_rev_r <= strap_sync_r[2];
      pwdn_odd_r <= strap_sync_r[3];
      pwdn_even_r <= strap_sync_r[4];
      rate_r <= strap_sync_r[6:5];
    end
  end

  // Port controls derived from the fields. Device reset holds both ports;
  // even power down also holds the odd port since they share the MAC.
  always @(posedge i_clk) begin
    if (!i_resetn) begin
      even_rst_r <= 1'b1;
      odd_rst_r <= 1'b1;
      even_pd_r <= 1'b0;
      odd_pd_r <= 1'b0;
      wide_ok_r <= 1'b0;
      odd_active_r <= 1'b0;
      rate_ok_r <= 1'b0;
    end else begin
      even_rst_r <= srst_even_r;
      odd_rst_r <= srst_odd_r | pwdn_even_r;
      even_pd_r <= pwdn_even_r;
      odd_pd_r <= pwdn_odd_r;
      wide_ok_r <= ~split_r;
      odd_active_r <= split_r;
      rate_ok_r <= spl_rate_ok(rate_r);
    end
  end

  // Readable images of the configuration and of the block's own state
  always @* begin
    cfg_word = 32'h0000_0000;
    cfg_word[`SPL_PER_LANE_LINE_LOOPBACK_MSB:`SPL_PER_LANE_LINE_LOOPBACK_LSB] = per_lane_line_loopback_r;
    cfg_word[`SPL_RSVD20_BIT] = rsvd20_r;
    cfg_word[`SPL_SPLIT_BIT] = split_r;
    cfg_word[`SPL_DLB_ODD_BIT] = dlb_odd_r;
    cfg_word[`SPL_DLB_EVEN_BIT] = dlb_even_r;
    cfg_word[`SPL_TX_REV_BIT] = tx_rev_r;
    cfg_word[`SPL_RX_REV_BIT] = rx_rev_r;
    cfg_word[`SPL_SRST_ODD_BIT] = srst_odd_r;
    cfg_word[`SPL_SRST_EVEN_BIT] = srst_even_r;
    cfg_word[`SPL_PWDN_ODD_BIT] = pwdn_odd_r;
    cfg_word[`SPL_PWDN_EVEN_BIT] = pwdn_even_r;
    cfg_word[`SPL_RATE_MSB:`SPL_RATE_LSB] = rate_r;
    stat_word = 32'h0000_0000;
    stat_word[`SPL_STAT_SPLIT_PIN] = strap_sync_r[0];
    stat_word[`SPL_STAT_TXREV_PIN] = strap_sync_r[1];
    stat_word[`SPL_STAT_RXREV_PIN] = strap_sync_r[2];
    stat_word[`SPL_STAT_PD_ODD_PIN] = strap_sync_r[3];
    stat_word[`SPL_STAT_PD_EVEN_PIN] = strap_sync_r[4];
    stat_word[`SPL_STAT_RATE_PIN_MSB:`SPL_STAT_RATE_PIN_LSB] = strap_sync_r[6:5];
    stat_word[`SPL_STAT_EVEN_RST] = even_rst_r;
    stat_word[`SPL_STAT_ODD_RST] = odd_rst_r;
    stat_word[`SPL_STAT_EVEN_PD] = even_pd_r;
    stat_word[`SPL_STAT_ODD_PD] = odd_pd_r;
    stat_word[`SPL_STAT_RATE_OK] = rate_ok_r;
    stat_word[`SPL_STAT_STRAP_DONE] = ~strap_pending_r;
  end

  // Read data select; unmapped addresses read as zero
  always @* begin
    if (i_addr == CFG_ADDR) begin
      rdata_nxt = cfg_word;
    end else if (i_addr == STAT_ADDR) begin
      rdata_nxt = stat_word;
    end else begin
      rdata_nxt = 32'h0000_0000;
    end
  end

  // Read data stand only in the cycle after the strobe, zero otherwise
  always @(posedge i_clk) begin
    if (!i_resetn) begin
      rdata_r <= 32'h0000_0000;
    end else if (i_rd) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  // Even port loopback ahead of the coder
  spl_port_loop #(
    .DW(DW)
  ) u_even_loop (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_hold(even_rst_r),
    .i_loop_en(dlb_even_r),
    .i_tx_data(i_even_tx_data),
    .i_dec_data(i_even_dec_data),
    .o_enc_data(o_even_enc_data),
    .o_rx_data(o_even_rx_data)
  );

  // Odd port loopback ahead of the coder
  spl_port_loop #(
    .DW(DW)
  ) u_odd_loop (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_hold(odd_rst_r),
    .i_loop_en(dlb_odd_r),
    .i_tx_data(i_odd_tx_data),
    .i_dec_data(i_odd_dec_data),
    .o_enc_data(o_odd_enc_data),
    .o_rx_data(o_odd_rx_data)
  );

  // Transmit lane order toward the SerDes
  spl_lane_order #(
    .LW(LW)
  ) u_tx_order (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_reverse(tx_rev_r),
    .i_lanes(i_tx_lanes),
    .o_lanes(o_tx_lanes)
  );

  // Receive lane order from the SerDes
  spl_lane_order #(
    .LW(LW)
  ) u_rx_order (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_reverse(rx_rev_r),
    .i_lanes(i_rx_lanes),
    .o_lanes(o_rx_lanes)
  );

  // Every control output is a flop; line loopback is only passed to the
  // SerDes, there is no retiming in that path so software should avoid it
  assign o_rdata = rdata_r;
  assign o_per_lane_line_loopback = per_lane_line_loopback_r;
  assign o_port_split_select = split_r;
  assign o_even_port_wide_allowed = wide_ok_r;
  assign o_odd_port_active = odd_active_r;
  assign o_even_port_reset = even_rst_r;
  assign o_odd_port_reset = odd_rst_r;
  assign o_even_port_power_down = even_pd_r;
  assign o_odd_port_power_down = odd_pd_r;
  assign o_lane_rate = rate_r;
  assign o_lane_rate_valid = rate_ok_r;

endmodule

//--- hw/spl_lane_order.v
`timescale 1ns/100ps
// Registered four-lane reorder: A,B,C,D straight or D,C,B,A reversed
module spl_lane_order #(
  parameter LW = 10
) (
  input wire i_clk,
  input wire i_resetn,
  input wire i_reverse,
  input wire [4*LW-1:0] i_lanes,
  output reg [4*LW-1:0] o_lanes
);

  // Swap lane slots end for end; lane A sits in the lowest slot
  function [4*LW-1:0] spl_reverse;
    input [4*LW-1:0] lanes;
    integer k;
    begin
      spl_reverse = {4*LW{1'b0}};
      for (k = 0; k < 4; k = k + 1) begin
        spl_reverse[k*LW +: LW] = lanes[(3-k)*LW +: LW];
      end
    end
  endfunction

  // One flop stage keeps the lane mux off the SerDes timing path
  always @(posedge i_clk) begin
    if (!i_resetn) begin
      o_lanes <= {4*LW{1'b0}};
    end else if (i_reverse) begin
      o_lanes <= spl_reverse(i_lanes);
    end else begin
      o_lanes <= i_lanes;
    end
  end

endmodule

//--- hw/spl_port_loop.v
`timescale 1ns/100ps
// Per-port digital loopback ahead of the 8b/10b coder
module spl_port_loop #(
  parameter DW = 9
) (
  input wire i_clk,
  input wire i_resetn,
  input wire i_hold,
  input wire i_loop_en,
  input wire [DW-1:0] i_tx_data,
  input wire [DW-1:0] i_dec_data,
  output reg [DW-1:0] o_enc_data,
  output reg [DW-1:0] o_rx_data
);

  // Held port gives quiet zeros both ways; transmit still reaches the coder in loopback
  always @(posedge i_clk) begin
    if (!i_resetn || i_hold) begin
      o_enc_data <= {DW{1'b0}};
      o_rx_data <= {DW{1'b0}};
    end else begin
      o_enc_data <= i_tx_data;
      if (i_loop_en) begin
        o_rx_data <= i_tx_data;
      end else begin
        o_rx_data <= i_dec_data;
      end
    end
  end

endmodule

//--- sim/spl_lane_cfg_asserts.sv
`timescale 1ns/100ps
// Port-side checks of the lane configuration register
module spl_chk #(
  parameter AW = 8,
  parameter DW = 9,
  parameter LW = 10
) (
  input wire i_clk,
  input wire i_resetn,
  input wire [AW-1:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [31:0] o_rdata,
  input wire [3:0] o_per_lane_line_loopback,
  input wire o_port_split_select,
  input wire o_even_port_wide_allowed,
  input wire o_odd_port_active,
  input wire o_even_port_reset,
  input wire o_odd_port_reset,
  input wire o_even_port_power_down,
  input wire o_odd_port_power_down,
  input wire [1:0] o_lane_rate,
  input wire o_lane_rate_valid,
  input wire [DW-1:0] o_even_enc_data,
  input wire [DW-1:0] o_even_rx_data,
  input wire [4*LW-1:0] i_tx_lanes,
  input wire [4*LW-1:0] o_tx_lanes
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  // Decoded config write and lanes in reversed slot order
  wire wr_cfg = i_wr && i_addr == 8'hc8;
  wire [4*LW-1:0] flip = {i_tx_lanes[LW-1:0], i_tx_lanes[2*LW-1:LW], i_tx_lanes[3*LW-1:2*LW], i_tx_lanes[4*LW-1:3*LW]};

  field_write_a: assert property (
    wr_cfg |=> o_per_lane_line_loopback == $past(i_wdata[19:16]) && o_port_split_select == $past(i_wdata[21])
      && o_lane_rate == $past(i_wdata[31:30])) else $error("config write not reflected");
  pd_write_a: assert property (
    wr_cfg |=> ##1 o_even_port_power_down == $past(i_wdata[29], 2) && o_odd_port_power_down == $past(i_wdata[28], 2))
    else $error("power down output wrong after write");
  read_back_a: assert property (
    i_rd && i_addr == 8'hc8 |=> o_rdata[19:16] == o_per_lane_line_loopback && o_rdata[31:30] == o_lane_rate)
    else $error("read data disagrees with field outputs");
  // Mode outputs lag the split field by one cycle; guard avoids the reset edge
  split_mode_a: assert property (
    $past(i_resetn) |-> o_even_port_wide_allowed == !$past(o_port_split_select)
      && o_odd_port_active == $past(o_port_split_select)) else $error("port mode outputs wrong");
  rate_valid_a: assert property (
    $past(i_resetn) |-> o_lane_rate_valid == ($past(o_lane_rate) != 2'h3)) else $error("rate valid wrong");
  pd_odd_reset_a: assert property (
    o_even_port_power_down |-> o_odd_port_reset) else $error("odd port not held with even power down");
  even_hold_a: assert property (
    o_even_port_reset && $past(o_even_port_reset) |-> o_even_rx_data == 0 && o_even_enc_data == 0)
    else $error("even port data moves while held");
  lane_order_a: assert property (
    $past(i_resetn) |-> o_tx_lanes == $past(i_tx_lanes) || o_tx_lanes == $past(flip))
    else $error("transmit lane order neither straight nor reversed");

  cover property (wr_cfg);
  cover property (o_even_port_power_down && o_odd_port_reset);
  cover property (o_lane_rate == 2'h3 && !o_lane_rate_valid);
endmodule

bind spl_lane_cfg spl_chk #(.AW(AW), .DW(DW), .LW(LW)) i_spl_chk (.i_clk, .i_resetn, .i_addr, .i_wdata, .i_wr,
  .i_rd, .o_rdata, .o_per_lane_line_loopback, .o_port_split_select, .o_even_port_wide_allowed, .o_odd_port_active,
  .o_even_port_reset, .o_odd_port_reset, .o_even_port_power_down, .o_odd_port_power_down, .o_lane_rate,
  .o_lane_rate_valid, .o_even_enc_data, .o_even_rx_data, .i_tx_lanes, .o_tx_lanes);

//--- sim/spl_lane_cfg_bench.sv
`timescale 1ns/100ps
module spl_lane_cfg_bench;
  logic i_clk = 0, i_resetn = 0, i_wr = 0, i_rd = 0;
  logic [7:0] i_addr = 8'h0;
  logic [31:0] i_wdata = 32'h0;
  logic i_port_split_strap_pin, i_transmit_reverse_strap_pin, i_receive_reverse_strap_pin;
  logic i_odd_port_power_down_strap_pin, i_even_port_power_down_strap_pin;
  logic [1:0] i_lane_rate_strap_pins;
  logic [8:0] i_even_tx_data = 9'h0, i_even_dec_data = 9'h0, i_odd_tx_data = 9'h0, i_odd_dec_data = 9'h0;
  logic [39:0] i_tx_lanes = 40'h0, i_rx_lanes = 40'h0;
  wire [31:0] o_rdata;
  wire [3:0] o_per_lane_line_loopback;
  wire o_port_split_select, o_even_port_wide_allowed, o_odd_port_active, o_even_port_reset, o_odd_port_reset;
  wire o_even_port_power_down, o_odd_port_power_down, o_lane_rate_valid;
  wire [1:0] o_lane_rate;
  wire [8:0] o_even_enc_data, o_even_rx_data, o_odd_enc_data, o_odd_rx_data;
  wire [39:0] o_tx_lanes, o_rx_lanes;
  logic rd_d = 0, st = 0, st_d = 0, dv = 0, dv_d = 0;
  int fail_count = 0, comparisons = 0;
  logic [31:0] r = 32'h40c67d45, d;
  logic [127:0] rq[$], sq[$], dq[$];

  spl_lane_cfg i_spl_lane_cfg (.i_clk, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_port_split_strap_pin, .i_transmit_reverse_strap_pin, .i_receive_reverse_strap_pin,
    .i_odd_port_power_down_strap_pin, .i_even_port_power_down_strap_pin, .i_lane_rate_strap_pins,
    .o_per_lane_line_loopback, .o_port_split_select, .o_even_port_wide_allowed, .o_odd_port_active,
    .o_even_port_reset, .o_odd_port_reset, .o_even_port_power_down, .o_odd_port_power_down, .o_lane_rate,
    .o_lane_rate_valid, .i_even_tx_data, .i_even_dec_data, .o_even_enc_data, .o_even_rx_data, .i_odd_tx_data,
    .i_odd_dec_data, .o_odd_enc_data, .o_odd_rx_data, .i_tx_lanes, .o_tx_lanes, .i_rx_lanes, .o_rx_lanes);

  // 100 ns clock
  initial forever #50 i_clk = ~i_clk;

  function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic [39:0] rev(input [39:0] l);
    rev = {l[9:0], l[19:10], l[29:20], l[39:30]};
  endfunction

  task check(input string n, input [127:0] s, input [127:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  // One register access per cycle; strobes stay up so accesses run back to back
  task acc(input w, input [7:0] a, input [31:0] wd, input [31:0] e);
    i_wr <= w;
    i_rd <= !w;
    i_addr <= a;
    i_wdata <= wd;
    if (!w) rq.push_back(e);
    @(posedge i_clk);
  endtask

  task idle;
    i_wr <= 0;
    i_rd <= 0;
    @(posedge i_clk);
  endtask

  task snap(input [13:0] e);
    sq.push_back(e);
    st <= 1;
    @(posedge i_clk);
    st <= 0;
    @(posedge i_clk);
  endtask

  // Random port words and lanes; held port expects silence on its data outputs
  task dat(input lp, input rv, input hr);
    logic [8:0] et, ed, ot, od;
    logic [39:0] tl, rl;
    r = lfsr(r);
    tl = {r, r[7:0]};
    r = lfsr(r);
    rl = {r, r[15:8]};
    r = lfsr(r);
    {et, ed, ot} = r[26:0];
    r = lfsr(r);
    od = r[8:0];
    i_even_tx_data <= et;
    i_even_dec_data <= ed;
    i_odd_tx_data <= ot;
    i_odd_dec_data <= od;
    i_tx_lanes <= tl;
    i_rx_lanes <= rl;
    dq.push_back({hr ? 9'h0 : lp ? et : ed, hr ? 9'h0 : lp ? ot : od, hr ? 9'h0 : et, hr ? 9'h0 : ot,
      rv ? rev(tl) : tl, rv ? rev(rl) : rl});
    dv <= 1;
    @(posedge i_clk);
  endtask

  // Results are judged in the cycle after their request, against the oldest note
  always @(posedge i_clk) begin
    if (rd_d) check("rdata", o_rdata, rq.pop_front());
    if (st_d) check("fields",
      {o_per_lane_line_loopback, o_port_split_select, o_even_port_wide_allowed, o_odd_port_active,
      o_even_port_reset, o_odd_port_reset, o_even_port_power_down, o_odd_port_power_down,
      o_lane_rate, o_lane_rate_valid}, sq.pop_front());
    if (dv_d) check("data",
      {o_even_rx_data, o_odd_rx_data, o_even_enc_data, o_odd_enc_data, o_tx_lanes,
      o_rx_lanes}, dq.pop_front());
    rd_d <= i_rd;
    st_d <= st;
    dv_d <= dv;
  end

  task print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Main sequence: straps, register traffic, data paths
  initial begin
    {i_port_split_strap_pin, i_transmit_reverse_strap_pin, i_receive_reverse_strap_pin,
      i_odd_port_power_down_strap_pin, i_even_port_power_down_strap_pin, i_lane_rate_strap_pins} <= r[6:0];
    repeat (5) @(posedge i_clk);
    i_resetn <= 1;
    @(posedge i_clk);
    acc(0, 8'hc8, 0, {i_lane_rate_strap_pins, i_even_port_power_down_strap_pin, i_odd_port_power_down_strap_pin,
      2'b0, i_receive_reverse_strap_pin, i_transmit_reverse_strap_pin, 2'b0, i_port_split_strap_pin, 21'h0});
    // Status image: strap levels plus the port controls that they produce
    acc(0, 8'hcc, 0, {18'h0, 1'b1, i_lane_rate_strap_pins != 2'h3, i_odd_port_power_down_strap_pin,
      i_even_port_power_down_strap_pin, i_even_port_power_down_strap_pin, 2'b0, i_lane_rate_strap_pins,
      i_even_port_power_down_strap_pin, i_odd_port_power_down_strap_pin, i_receive_reverse_strap_pin,
      i_transmit_reverse_strap_pin, i_port_split_strap_pin});
    acc(0, 8'h10, 0, 0);
    idle;
    $display("test straps done");
    // Every rate code; status writes and low bits must be ignored
    for (int i = 0; i < 8; i++) begin
      r = lfsr(r);
      d = {i[1:0], r[29:0]};
      acc(1, 8'hc8, d, 0);
      acc(0, 8'hc8, 0, d & 32'hffff0000);
      acc(1, 8'hcc, ~d, 0);
      acc(0, 8'hc8, 0, d & 32'hffff0000);
      acc(0, 8'h10, 0, 0);
      idle;
      snap({d[19:16], d[21], !d[21], d[21], d[27], d[26] | d[29], d[29], d[28], d[31:30], d[31:30] != 2'h3});
    end
    $display("test registers done");
    // Loopback, lane reversal and soft reset in all combinations; line loopback stays off
    for (int i = 0; i < 8; i++) begin
      acc(1, 8'hc8, {2'h2, 2'h0, {2{i[2]}}, {2{i[1]}}, {2{i[0]}}, 22'h0}, 0);
      idle;
      idle;
      idle;
      repeat (4) dat(i[0], i[1], i[2]);
      dv <= 0;
      idle;
    end
    // Let the last data note be judged before the run ends
    idle;
    $display("test data path done");
    print_verdict;
  end

  // Run needs about 150 cycles; this cuts a hang well beyond that
  initial begin
    repeat (3000) @(posedge i_clk);
    fail_count++;
    print_verdict;
  end
endmodule
